// ==== core/rcm_clock_mgmt.sv ====
// regulator clock management: trim stepping, spreading, sync in/out, apb registers
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rcm_clock_mgmt #(
    parameter int SS_PERIOD_CYC = rcm_pkg::RCM_SS_PERIOD_CYC,
    parameter int STEP_CYC = rcm_pkg::RCM_STEP_CYC,
    parameter int LP_DIV = rcm_pkg::RCM_LP_DIV
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] default_trim_code,
    input wire logic default_spread_enable,
    input wire logic default_spread_wide_sel,
    input wire logic default_sync_band_sel,
    input wire logic default_sync_out_enable,
    input wire logic ext_sync_permit,
    input wire logic ext_sync_in,
    output logic [3:0] hf_trim_code,
    output logic spread_active,
    output logic spread_wide_sel,
    output logic pll_enable,
    output logic ext_source_sel,
    output logic lp_tick,
    output logic sync_out_pin,
    output logic irq_out_n
);
    import rcm_pkg::*;

    localparam int SS_STEP_CYC = SS_PERIOD_CYC / RCM_SS_STEPS;

    ////////////////////////////////////////////////////////////////////////////
    // trim code <-> linear step index (0 = 16 MHz .. 8 = 24 MHz)
    function automatic logic code_used(input logic [3:0] c);
        code_used = (c <= RCM_TRIM_HIGH_LAST) ||
                    (c >= RCM_TRIM_LOW_FIRST && c <= RCM_TRIM_LOW_LAST);
    endfunction

    function automatic logic [3:0] code_to_idx(input logic [3:0] c);
        if (c <= RCM_TRIM_HIGH_LAST)
        begin
            code_to_idx = c + RCM_TRIM_IDX_NOMINAL;
        end
        else
        begin
            code_to_idx = c - RCM_TRIM_LOW_FIRST;
        end
    endfunction

    function automatic logic [3:0] idx_to_code(input logic [3:0] i);
        if (i >= RCM_TRIM_IDX_NOMINAL)
        begin
            idx_to_code = i - RCM_TRIM_IDX_NOMINAL;
        end
        else
        begin
            idx_to_code = i + RCM_TRIM_LOW_FIRST;
        end
    endfunction

    // nco increment for hf/8 against the system clock
    function automatic logic [RCM_NCO_BITS-1:0] sw_inc(input logic [3:0] i);
        int mhz;
        mhz = RCM_HF_MIN_MHZ + int'(i);
        sw_inc = RCM_NCO_BITS'((mhz * (1 << RCM_NCO_BITS)) / (RCM_HF_DIV * (RCM_SYS_CLK_KHZ / 1000)));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic init_done_reg, init_done_next;
    rcm_ctrl_t ctrl_reg, ctrl_next;
    logic [1:0] flag_reg, flag_next;
    logic [1:0] mask_reg, mask_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pslverr_reg, pslverr_next;
    logic [3:0] cur_idx_reg, cur_idx_next;
    logic [15:0] step_cnt_reg, step_cnt_next;
    logic [15:0] lp_cnt_reg, lp_cnt_next;
    logic [15:0] ss_cnt_reg, ss_cnt_next;
    logic [8:0] tri_reg, tri_next;
    logic tri_up_reg, tri_up_next;
    logic [RCM_NCO_BITS-1:0] acc_reg, acc_next;
    logic sync_d_reg, sync_d_next;
    logic [11:0] per_cnt_reg, per_cnt_next;
    logic raw_valid_reg, raw_valid_next;
    logic sync_valid_reg, sync_valid_next;
    logic fault_d_reg, fault_d_next;
    logic use_ext_reg, use_ext_next;

    logic wr_en, setup_rd, lp_en, ext_req, tune_ok, sync_rise, fault_live;
    logic [3:0] tgt_idx;
    logic [11:0] per_min, per_max;
    logic [RCM_NCO_BITS-1:0] inc_nom, max_dev, inc_eff;
    logic [RCM_NCO_BITS+8:0] dev_prod;
    rcm_status_t status;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        pready = init_done_reg;
        wr_en = psel && penable && pwrite && init_done_reg;
        setup_rd = psel && !penable;
        lp_en = (lp_cnt_reg == 16'(LP_DIV - 1));
        ext_req = ext_sync_permit && ctrl_reg.ext_sync_enable;
        tune_ok = !spread_active && !ext_req;
        tgt_idx = code_to_idx(ctrl_reg.hf_trim_code);
        sync_rise = ext_sync_in && !sync_d_reg;
        fault_live = ext_req && !sync_valid_reg;
        per_min = ctrl_reg.sync_band_sel ? 12'(RCM_B1_PER_MIN) : 12'(RCM_B0_PER_MIN);
        per_max = ctrl_reg.sync_band_sel ? 12'(RCM_B1_PER_MAX) : 12'(RCM_B0_PER_MAX);
        inc_nom = sw_inc(cur_idx_reg);
        max_dev = ctrl_reg.spread_wide_sel ? inc_nom / 24'ha : inc_nom / 24'h14;
        dev_prod = (RCM_NCO_BITS+9)'(max_dev) * (RCM_NCO_BITS+9)'(tri_reg);
        inc_eff = spread_active ? inc_nom - max_dev + dev_prod[RCM_NCO_BITS+6:7] : inc_nom;
        status = '{spread_active: spread_active, ext_sync_permit: ext_sync_permit,
                   ext_source: use_ext_reg, sync_fault_live: fault_live,
                   trim_busy: cur_idx_reg != tgt_idx, trim_applied: idx_to_code(cur_idx_reg)};

        init_done_next = 1'b1;
        ctrl_next = ctrl_reg;
        flag_next = flag_reg;
        mask_next = mask_reg;
        prdata_next = prdata_reg;
        pslverr_next = pslverr_reg;
        cur_idx_next = cur_idx_reg;
        step_cnt_next = step_cnt_reg;
        lp_cnt_next = lp_en ? 16'h0000 : lp_cnt_reg + 16'h0001;
        ss_cnt_next = ss_cnt_reg;
        tri_next = tri_reg;
        tri_up_next = tri_up_reg;
        acc_next = acc_reg + inc_eff;
        sync_d_next = ext_sync_in;
        per_cnt_next = per_cnt_reg;
        raw_valid_next = raw_valid_reg;
        sync_valid_next = sync_valid_reg;
        fault_d_next = fault_d_reg;
        use_ext_next = use_ext_reg;

        // straps caught once, the cycle after reset release
        if (!init_done_reg)
        begin
            ctrl_next.hf_trim_code = code_used(default_trim_code) ? default_trim_code : 4'h0;
            ctrl_next.spread_enable = default_spread_enable;
            ctrl_next.spread_wide_sel = default_spread_wide_sel;
            ctrl_next.sync_band_sel = default_sync_band_sel;
            ctrl_next.sync_out_enable = default_sync_out_enable;
            cur_idx_next = code_used(default_trim_code) ? code_to_idx(default_trim_code)
                                                        : RCM_TRIM_IDX_NOMINAL;
        end

        // apb: read data latched in the setup cycle, zero-wait access phase
        if (setup_rd)
        begin
            pslverr_next = paddr[11:4] != 8'h00 || paddr[1:0] != 2'h0;
            unique case (paddr[3:0])
                RCM_ADDR_CTRL: prdata_next = 32'(ctrl_reg);
                RCM_ADDR_STATUS: prdata_next = 32'(status);
                RCM_ADDR_FLAGS: prdata_next = 32'(flag_reg);
                RCM_ADDR_MASK: prdata_next = 32'(mask_reg);
                default: prdata_next = 32'h0000_0000;
            endcase
            if (pslverr_next)
            begin
                prdata_next = 32'h0000_0000;
            end
        end

        if (wr_en && !pslverr_reg)
        begin
            unique case (paddr[3:0])
                RCM_ADDR_CTRL:
                begin
                    ctrl_next = rcm_ctrl_t'(pwdata[$bits(rcm_ctrl_t)-1:0]);
                    if (!code_used(pwdata[3:0]))
                    begin
                        ctrl_next.hf_trim_code = ctrl_reg.hf_trim_code;
                    end
                end
                RCM_ADDR_FLAGS: flag_next = flag_reg & ~pwdata[1:0];
                RCM_ADDR_MASK: mask_next = pwdata[1:0];
                default: ;
            endcase
        end

        // trim walk: first step at once, later steps spaced by the step time
        if (step_cnt_reg != 16'h0000)
        begin
            step_cnt_next = step_cnt_reg - 16'h0001;
        end
        else if (tune_ok && init_done_reg && cur_idx_reg != tgt_idx)
        begin
            cur_idx_next = (tgt_idx > cur_idx_reg) ? cur_idx_reg + 4'h1 : cur_idx_reg - 4'h1;
            step_cnt_next = 16'(STEP_CYC - 1);
            if (cur_idx_next == tgt_idx)
            begin
                flag_next[RCM_FLAG_TRIM_BIT] = 1'b1;
            end
        end

        // triangle spread profile, one full sweep per modulation period
        if (!spread_active)
        begin
            ss_cnt_next = 16'h0000;
            tri_next = 9'h080;
            tri_up_next = 1'b1;
        end
        else if (ss_cnt_reg == 16'(SS_STEP_CYC - 1))
        begin
            ss_cnt_next = 16'h0000;
            tri_next = tri_up_reg ? tri_reg + 9'h001 : tri_reg - 9'h001;
            if (tri_up_reg && tri_reg == 9'h0ff)
            begin
                tri_up_next = 1'b0;
            end
            else if (!tri_up_reg && tri_reg == 9'h001)
            begin
                tri_up_next = 1'b1;
            end
        end
        else
        begin
            ss_cnt_next = ss_cnt_reg + 16'h0001;
        end

        // sync input period check against the selected band
        if (sync_rise)
        begin
            per_cnt_next = 12'h000;
            raw_valid_next = (per_cnt_reg + 12'h001 >= per_min) &&
                             (per_cnt_reg + 12'h001 <= per_max);
        end
        else if (per_cnt_reg > per_max)
        begin
            raw_valid_next = 1'b0;
        end
        else
        begin
            per_cnt_next = per_cnt_reg + 12'h001;
        end

        // slow debounce of validity on the low-power tick
        if (lp_en)
        begin
            sync_valid_next = raw_valid_reg;
            fault_d_next = fault_live;
        end
        if (lp_en && fault_live && !fault_d_reg)
        begin
            flag_next[RCM_FLAG_SYNC_BIT] = 1'b1;
        end

        if (!ext_req)
        begin
            use_ext_next = 1'b0;
        end
        else if (use_ext_reg && !sync_valid_reg)
        begin
            use_ext_next = 1'b0;
        end
        else if (!use_ext_reg && sync_valid_reg && !flag_reg[RCM_FLAG_SYNC_BIT])
        begin
            use_ext_next = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            init_done_reg <= 1'b0;
            ctrl_reg <= '0;
            flag_reg <= 2'h0;
            mask_reg <= RCM_MASK_RESET;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            cur_idx_reg <= RCM_TRIM_IDX_NOMINAL;
            step_cnt_reg <= 16'h0000;
            lp_cnt_reg <= 16'h0000;
            ss_cnt_reg <= 16'h0000;
            tri_reg <= 9'h080;
            tri_up_reg <= 1'b1;
            acc_reg <= '0;
            sync_d_reg <= 1'b0;
            per_cnt_reg <= 12'h000;
            raw_valid_reg <= 1'b0;
            sync_valid_reg <= 1'b0;
            fault_d_reg <= 1'b0;
            use_ext_reg <= 1'b0;
        end
        else
        begin
            init_done_reg <= init_done_next;
            ctrl_reg <= ctrl_next;
            flag_reg <= flag_next;
            mask_reg <= mask_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
            cur_idx_reg <= cur_idx_next;
            step_cnt_reg <= step_cnt_next;
            lp_cnt_reg <= lp_cnt_next;
            ss_cnt_reg <= ss_cnt_next;
            tri_reg <= tri_next;
            tri_up_reg <= tri_up_next;
            acc_reg <= acc_next;
            sync_d_reg <= sync_d_next;
            per_cnt_reg <= per_cnt_next;
            raw_valid_reg <= raw_valid_next;
            sync_valid_reg <= sync_valid_next;
            fault_d_reg <= fault_d_next;
            use_ext_reg <= use_ext_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs; the sync pin follows the input pin while locked to it
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg && psel && penable;
    assign hf_trim_code = idx_to_code(cur_idx_reg);
    assign spread_active = ctrl_reg.spread_enable && !ext_req;
    assign spread_wide_sel = ctrl_reg.spread_wide_sel;
    assign pll_enable = ext_sync_permit;
    assign ext_source_sel = use_ext_reg;
    assign lp_tick = lp_en;
    assign sync_out_pin = ctrl_reg.sync_out_enable &&
                          (use_ext_reg ? sync_d_reg : acc_reg[RCM_NCO_BITS-1]);
    assign irq_out_n = !(|(flag_reg & ~mask_reg));

endmodule // rcm_clock_mgmt
`default_nettype wire

// ==== core/rcm_pkg.sv ====
// constants, types and register map of the regulator clock management block
package rcm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [3:0] RCM_ADDR_CTRL = 4'h0;
    localparam logic [3:0] RCM_ADDR_STATUS = 4'h4;
    localparam logic [3:0] RCM_ADDR_FLAGS = 4'h8;
    localparam logic [3:0] RCM_ADDR_MASK = 4'hc;

    localparam int RCM_FLAG_TRIM_BIT = 0;
    localparam int RCM_FLAG_SYNC_BIT = 1;
    localparam logic [1:0] RCM_MASK_RESET = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    localparam int RCM_SYS_CLK_KHZ = 250000;
    localparam int RCM_LP_CLK_KHZ = 100;
    localparam int RCM_LP_DIV = RCM_SYS_CLK_KHZ / RCM_LP_CLK_KHZ;
    localparam int RCM_STEP_TIME_NS = 5200;
    localparam int RCM_STEP_CYC = (RCM_STEP_TIME_NS * (RCM_SYS_CLK_KHZ / 1000) + 999) / 1000;
    localparam int RCM_SS_MOD_HZ = 24000;
    localparam int RCM_SS_PERIOD_CYC = (RCM_SYS_CLK_KHZ * 1000) / RCM_SS_MOD_HZ;
    localparam int RCM_SS_STEPS = 512;
    localparam int RCM_HF_DIV = 8;
    localparam int RCM_NCO_BITS = 24;

    localparam int RCM_BAND0_MIN_KHZ = 2000;
    localparam int RCM_BAND0_MAX_KHZ = 3000;
    localparam int RCM_BAND1_MIN_KHZ = 333;
    localparam int RCM_BAND1_MAX_KHZ = 500;
    localparam int RCM_B0_PER_MIN = (RCM_SYS_CLK_KHZ + RCM_BAND0_MAX_KHZ - 1) / RCM_BAND0_MAX_KHZ;
    localparam int RCM_B0_PER_MAX = RCM_SYS_CLK_KHZ / RCM_BAND0_MIN_KHZ;
    localparam int RCM_B1_PER_MIN = (RCM_SYS_CLK_KHZ + RCM_BAND1_MAX_KHZ - 1) / RCM_BAND1_MAX_KHZ;
    localparam int RCM_B1_PER_MAX = RCM_SYS_CLK_KHZ / RCM_BAND1_MIN_KHZ;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [3:0] RCM_TRIM_LOW_FIRST = 4'h9;
    localparam logic [3:0] RCM_TRIM_LOW_LAST = 4'hc;
    localparam logic [3:0] RCM_TRIM_HIGH_LAST = 4'h4;
    localparam logic [3:0] RCM_TRIM_IDX_NOMINAL = 4'h4;
    localparam int RCM_HF_MIN_MHZ = 16;

    typedef struct packed {
        logic sync_out_enable;
        logic sync_band_sel;
        logic ext_sync_enable;
        logic spread_wide_sel;
        logic spread_enable;
        logic [3:0] hf_trim_code;
    } rcm_ctrl_t;

    typedef struct packed {
        logic spread_active;
        logic ext_sync_permit;
        logic ext_source;
        logic sync_fault_live;
        logic trim_busy;
        logic [3:0] trim_applied;
    } rcm_status_t;

endpackage

// ==== dv/rcm_clock_mgmt_chk.sv ====
// port checker for the regulator clock management block
`timescale 1ns/1ps
`default_nettype none
module rcm_clock_mgmt_chk #(
    parameter int LP_DIV = 10
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic ext_sync_permit,
    input wire logic [3:0] hf_trim_code,
    input wire logic spread_active,
    input wire logic spread_wide_sel,
    input wire logic pll_enable,
    input wire logic ext_source_sel,
    input wire logic lp_tick,
    input wire logic sync_out_pin,
    input wire logic irq_out_n
);
    import rcm_pkg::*;
    logic [1:0] live;
    logic [15:0] tcnt;
    logic tseen;
    logic esp;
    logic ewd;
    logic wr;
    assign wr = psel && penable && pready && pwrite && (paddr == {8'h00, RCM_ADDR_CTRL});
    function automatic int lin(input logic [3:0] c);
        return (c <= 4'h4) ? int'(c) + 4 : int'(c) - 9;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // strap load right after reset may jump, so steps are judged from the fourth edge
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            live <= 2'h0;
            tcnt <= 16'h0;
            tseen <= 1'b0;
            esp <= 1'b0;
            ewd <= 1'b0;
        end
        else
        begin
            live <= (live == 2'h3) ? live : live + 2'h1;
            tcnt <= lp_tick ? 16'h0 : tcnt + 16'h1;
            tseen <= tseen | lp_tick;
            esp <= wr ? (pwdata[4] && !(pwdata[6] && ext_sync_permit)) : esp;
            ewd <= wr ? pwdata[5] : ewd;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_tick_period: assert property (
        tseen && (lp_tick || tcnt >= LP_DIV - 1) |-> lp_tick && tcnt == LP_DIV - 1)
        else $error("slow tick spacing wrong");
    a_trim_used: assert property (
        (hf_trim_code <= 4'h4) || (hf_trim_code inside {[4'h9:4'hc]}))
        else $error("unused trim code applied");
    a_trim_adjacent: assert property (
        live == 2'h3 && $changed(hf_trim_code)
        |-> (lin(hf_trim_code) - lin($past(hf_trim_code))) inside {1, -1})
        else $error("trim skipped a step");
    a_spread_bit: assert property (
        wr |=> spread_active == esp)
        else $error("spread state wrong after control write");
    a_spread_range: assert property (
        wr |=> spread_wide_sel == ewd)
        else $error("spread range wrong after control write");
    a_sync_out_off: assert property (
        wr && !pwdata[8] |=> ##1 (!sync_out_pin) [*2])
        else $error("sync output not low when disabled");
    a_pll_permit: assert property (
        pll_enable == ext_sync_permit)
        else $error("pll enable differs from permit");
    a_no_ext_source: assert property (
        !ext_sync_permit && !$past(ext_sync_permit) && !$past(ext_sync_permit, 2)
        |-> !ext_source_sel)
        else $error("external source without permit");
    c_trim_move: cover property ($changed(hf_trim_code));
    c_ext_on: cover property ($rose(ext_source_sel));
    c_irq_low: cover property ($fell(irq_out_n));
endmodule // rcm_clock_mgmt_chk

bind rcm_clock_mgmt rcm_clock_mgmt_chk #(.LP_DIV(LP_DIV)) u_rcm_clock_mgmt_chk (
    .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .ext_sync_permit(ext_sync_permit),
    .hf_trim_code(hf_trim_code), .spread_active(spread_active),
    .spread_wide_sel(spread_wide_sel), .pll_enable(pll_enable),
    .ext_source_sel(ext_source_sel), .lp_tick(lp_tick), .sync_out_pin(sync_out_pin),
    .irq_out_n(irq_out_n));
`default_nettype wire

// ==== dv/rcm_sync_src.sv ====
// external sync clock source standing at the far side of the sync input
`timescale 1ns/1ps
`default_nettype none
module rcm_sync_src (
    input wire logic clk_sys,
    input wire logic run,
    input wire logic [15:0] period,
    output logic ext_sync_in
);
    logic [15:0] cnt = 16'h0;
    logic q = 1'b0;
    assign ext_sync_in = q;
    // stopped source holds the pin low, so a late start never looks like a clock
    always @(posedge clk_sys)
    begin
        if (!run)
        begin
            cnt <= 16'h0;
            q <= 1'b0;
        end
        else
        begin
            cnt <= (cnt >= period - 16'h1) ? 16'h0 : cnt + 16'h1;
            q <= (cnt < (period >> 1));
        end
    end
endmodule // rcm_sync_src
`default_nettype wire

// ==== dv/rcm_clock_mgmt_tb.sv ====
// self-checking bench of the regulator clock management block
`timescale 1ns/1ps
`default_nettype none
module rcm_clock_mgmt_tb;
    import rcm_pkg::*;
    localparam int STEP = 8;
    localparam logic [11:0] A_CTRL = {8'h00, RCM_ADDR_CTRL};
    localparam logic [11:0] A_STAT = {8'h00, RCM_ADDR_STATUS};
    localparam logic [11:0] A_FLAG = {8'h00, RCM_ADDR_FLAGS};
    localparam logic [11:0] A_MASK = {8'h00, RCM_ADDR_MASK};
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] q;
        logic e;
    } rcm_row_t;
    rcm_row_t rows [7] = '{'{12'h000, 32'h130, 32'h130, 1'b0},
        '{12'h000, 32'h100, 32'h100, 1'b0}, '{12'h00c, 32'h3, 32'h3, 1'b0},
        '{12'h00c, 32'h0, 32'h0, 1'b0}, '{12'h004, 32'h1ff, 32'h80, 1'b0},
        '{12'h010, 32'h5, 32'h0, 1'b1}, '{12'h002, 32'h5, 32'h0, 1'b1}};
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] dtrim = 4'ha;
    logic permit = 1'b1;
    logic src_run = 1'b0;
    logic [15:0] src_per = 16'h0064;
    logic pready, pslverr, spread_active, spread_wide_sel, pll_enable, ext_source_sel;
    logic lp_tick, sync_out_pin, irq_out_n, ext_sync_in, er, hi;
    logic [3:0] hf_trim_code;
    logic [31:0] prdata;
    logic [31:0] rd;
    int errors = 0;
    int n_checks = 0;
    int m, k;
    always #2 clk_sys = ~clk_sys;
    rcm_clock_mgmt #(.SS_PERIOD_CYC(1024), .STEP_CYC(STEP), .LP_DIV(10)) u_rcm_clock_mgmt (
        .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .default_trim_code(dtrim), .default_spread_enable(1'b0),
        .default_spread_wide_sel(dtrim[3]), .default_sync_band_sel(1'b0),
        .default_sync_out_enable(1'b1), .ext_sync_permit(permit), .ext_sync_in(ext_sync_in),
        .hf_trim_code(hf_trim_code), .spread_active(spread_active),
        .spread_wide_sel(spread_wide_sel), .pll_enable(pll_enable),
        .ext_source_sel(ext_source_sel), .lp_tick(lp_tick), .sync_out_pin(sync_out_pin),
        .irq_out_n(irq_out_n));
    rcm_sync_src u_rcm_sync_src (.clk_sys(clk_sys), .run(src_run), .period(src_per),
        .ext_sync_in(ext_sync_in));
    ////////////////////////////////////////////////////////////////////////////
    function automatic int lin(input logic [3:0] c);
        return (c <= 4'h4) ? int'(c) + 4 : int'(c) - 9;
    endfunction
    function automatic logic [3:0] code_of(input int i);
        return (i < 4) ? 4'(i + 9) : 4'(i - 4);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t %s: got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic end_test(input string s);
        $display("test %s done", s);
    endtask
    // request held until the edge that samples pready high
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
        begin
            @(posedge clk_sys);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic flg(input logic irqv, input logic [31:0] fl);
        repeat (3) @(posedge clk_sys);
        chk(irq_out_n, irqv, "irq level");
        xfer(A_FLAG, 1'b0, 32'h0);
        chk(rd, fl, "flags");
        xfer(A_FLAG, 1'b1, fl);
    endtask
    task automatic wait_ext(input logic v);
        int n;
        n = 0;
        while (ext_source_sel !== v && n < 3000)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk(ext_source_sel, v, "source select");
    endtask
    task automatic do_reset(input logic [3:0] t, input logic [31:0] q);
        @(posedge clk_sys);
        dtrim <= t;
        rstn <= 1'b0;
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(hf_trim_code, q[3:0], "strap trim");
        xfer(A_CTRL, 1'b0, 32'h0);
        chk(rd, q, "ctrl reset");
        xfer(A_MASK, 1'b0, 32'h0);
        chk(rd, 32'(RCM_MASK_RESET), "mask reset");
    endtask
    // every step is expected in the linear 16..24 MHz order; steps after the first are checked to be STEP cycles apart
    task automatic walk(input logic [31:0] c, input logic [3:0] from);
        int i, j, n, s;
        logic [3:0] last;
        i = lin(from);
        j = lin(c[3:0]);
        last = from;
        s = 0;
        xfer(A_CTRL, 1'b1, c);
        while (i != j)
        begin
            i = (j > i) ? i + 1 : i - 1;
            n = 0;
            while (hf_trim_code === last && n < 4 * STEP)
            begin
                @(posedge clk_sys);
                n++;
            end
            chk(hf_trim_code, code_of(i), "trim step");
            if (s > 0)
                chk(n, STEP, "step gap");
            last = hf_trim_code;
            s++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test;
    end
    initial
    begin
        do_reset(4'ha, 32'h12a);
        do_reset(4'h6, 32'h100);
        end_test("reset");
        foreach (rows[i])
        begin
            xfer(rows[i].a, 1'b1, rows[i].d);
            chk(er, rows[i].e, "write error");
            xfer(rows[i].a, 1'b0, 32'h0);
            chk(rd, rows[i].q, "read back");
            chk(er, rows[i].e, "read error");
        end
        end_test("registers");
        walk(32'h109, 4'h0);
        flg(1'b0, 32'h1);
        xfer(A_MASK, 1'b1, 32'h1);
        walk(32'h104, 4'h9);
        flg(1'b1, 32'h1);
        xfer(A_MASK, 1'b1, 32'h0);
        end_test("trim walk");
        for (k = 5; k < 16; k++)
            if (k < 9 || k > 12)
                xfer(A_CTRL, 1'b1, 32'h100 | 32'(k));
        repeat (4 * STEP) @(posedge clk_sys);
        chk(hf_trim_code, 4'h4, "unused code hold");
        xfer(A_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h104, "unused code ctrl");
        flg(1'b1, 32'h0);
        end_test("unused codes");
        xfer(A_CTRL, 1'b1, 32'h110);
        repeat (6 * STEP) @(posedge clk_sys);
        chk(hf_trim_code, 4'h4, "frozen while spreading");
        walk(32'h100, 4'h4);
        flg(1'b0, 32'h1);
        end_test("spread freeze");
        src_run <= 1'b1;
        m = 0;
        k = 0;
        hi = sync_out_pin;
        while (k < 2 && m < 1000)
        begin
            @(posedge clk_sys);
            m++;
            if (sync_out_pin === 1'b1 && hi === 1'b0)
            begin
                k++;
                if (k == 1)
                    m = 0;
            end
            hi = sync_out_pin;
        end
        chk(m, 100, "sync out period");
        xfer(A_CTRL, 1'b1, 32'h000);
        repeat (2) @(posedge clk_sys);
        hi = 1'b0;
        repeat (200)
        begin
            @(posedge clk_sys);
            hi = hi | (sync_out_pin !== 1'b0);
        end
        chk(hi, 1'b0, "sync out held low");
        end_test("sync out");
        xfer(A_CTRL, 1'b1, 32'h140);
        wait_ext(1'b1);
        xfer(A_CTRL, 1'b1, 32'h150);
        repeat (2) @(posedge clk_sys);
        chk(spread_active, 1'b0, "spread forced off");
        xfer(A_STAT, 1'b0, 32'h0);
        chk(rd[5], 1'b0, "live fault");
        src_run <= 1'b0;
        wait_ext(1'b0);
        xfer(A_STAT, 1'b0, 32'h0);
        chk(rd[5], 1'b1, "live fault");
        src_run <= 1'b1;
        repeat (2000) @(posedge clk_sys);
        chk(irq_out_n, 1'b0, "fault irq");
        chk(ext_source_sel, 1'b0, "stays internal");
        xfer(A_STAT, 1'b0, 32'h0);
        chk(rd[5], 1'b0, "live fault");
        flg(1'b0, 32'h2);
        wait_ext(1'b1);
        end_test("sync fault");
        src_per <= 16'h0258;
        wait_ext(1'b0);
        xfer(A_CTRL, 1'b1, 32'h1d0);
        repeat (2000) @(posedge clk_sys);
        xfer(A_STAT, 1'b0, 32'h0);
        chk(rd[5], 1'b0, "low band valid");
        flg(1'b0, 32'h2);
        wait_ext(1'b1);
        end_test("sync band");
        permit <= 1'b0;
        wait_ext(1'b0);
        chk(pll_enable, 1'b0, "pll off");
        end_test("no permit");
        stop_test;
    end
endmodule // rcm_clock_mgmt_tb
`default_nettype wire
